// file: hw/programmable_logic_block.sv
// Eight-cell programmable logic block with shared clock, enable and set/reset
`timescale 1ns/100ps
module programmable_logic_block (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [programmable_logic_block_pkg::NUM_GLOBAL_BUFFERS-1:0] global_clock_buffer,
    input wire logic fabric_clock,
    input wire logic fabric_enable,
    input wire logic fabric_set_reset,
    input wire programmable_logic_block_pkg::block_cfg_s block_cfg,
    input wire programmable_logic_block_pkg::cell_cfg_s [7:0] cell_cfg,
    input wire logic [7:0][3:0] lut_in,
    input wire logic carry_chain_in,
    output logic [7:0] cell_out,
    output logic carry_chain_out
);
    import programmable_logic_block_pkg::*;

    logic sel_clk;
    logic sel_clk_q;
    logic tick;
    logic ce_sig;
    logic sr_sig;
    logic ce_on;
    logic sr_apply;
    logic [NUM_CELLS-1:0] ff;
    logic [NUM_CELLS-1:0] lut_val;
    logic [NUM_CELLS-1:0] sr_vals;
    logic [NUM_CELLS-1:0] out_mux;
    logic [NUM_CELLS:0] carry;
    logic [NUM_CELLS-1:0] next_ff;
    logic load_en;
    logic sr_sync_hit;
    logic sr_async_hit;
    logic woke;

    // Shared clock source: sampled and edge-detected so all cells share one tick
    assign sel_clk = (block_cfg.clk_sel == CLK_SEL_FABRIC) ? fabric_clock :
        global_clock_buffer[block_cfg.clk_sel[2:0]];
    assign tick = sel_clk & ~sel_clk_q;

    // Control sources: enable from odd buffers, set/reset from even buffers
    assign ce_sig = block_cfg.ce_from_global_clock_buffer ?
        global_clock_buffer[{block_cfg.ce_global_clock_buffer_pair, 1'b1}] : fabric_enable;
    assign sr_sig = block_cfg.sr_from_global_clock_buffer ?
        global_clock_buffer[{block_cfg.sr_global_clock_buffer_pair, 1'b0}] : fabric_set_reset;
    assign ce_on = !block_cfg.ce_used || ce_sig;
    // Load and set/reset qualifiers shared by all cells
    assign load_en = tick && ce_on;
    assign sr_sync_hit = block_cfg.sr_used && !block_cfg.sr_async && sr_sig && tick;
    assign sr_async_hit = block_cfg.sr_used && block_cfg.sr_async && sr_sig;
    assign sr_apply = sr_sync_hit || sr_async_hit;

    assign carry[0] = carry_chain_in;

    // One cell per iteration: table, carry, output select and next state
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
            assign lut_val[gi] = cell_cfg[gi].lut_init[lut_in[gi]];
            assign carry[gi+1] = (lut_in[gi][1] & lut_in[gi][2]) |
                ((lut_in[gi][1] | lut_in[gi][2]) & carry[gi]);
            assign sr_vals[gi] = cell_cfg[gi].sr_to_set;
            assign out_mux[gi] = cell_cfg[gi].reg_out ? ff[gi] : lut_val[gi];
            assign next_ff[gi] = sr_apply ? sr_vals[gi] :
                (load_en ? lut_val[gi] : ff[gi]);
        end
    endgenerate

    // Cell registers and registered outputs
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sel_clk_q <= 1'b0;
            ff <= {NUM_CELLS{FF_WAKE_VALUE}};
            cell_out <= '0;
            carry_chain_out <= 1'b0;
        end else begin
            sel_clk_q <= sel_clk;
            ff <= next_ff;
            cell_out <= out_mux;
            carry_chain_out <= carry[NUM_CELLS];
        end
    end

    // Reference sum of the second and third inputs across the chain
    logic [NUM_CELLS-1:0] add_a;
    logic [NUM_CELLS-1:0] add_b;
    logic [NUM_CELLS:0] add_sum;
    always_comb begin
        for (int k = 0; k < NUM_CELLS; k++) begin
            add_a[k] = lut_in[k][1];
            add_b[k] = lut_in[k][2];
        end
        add_sum = {1'b0, add_a} + {1'b0, add_b} + {{NUM_CELLS{1'b0}}, carry_chain_in};
    end

    // Marks the first load or set/reset after the global reset
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            woke <= 1'b0;
        end else if (load_en || sr_apply) begin
            woke <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Global reset and wake-up state
    chk_wake_reset: assert property ($past(!nrst) |-> ff == '0)
        else $error("Flip-flops not cleared after global reset");
    chk_reset_outputs: assert property ($past(!nrst)
        |-> cell_out == '0 && !carry_chain_out)
        else $error("Outputs not cleared after global reset");
    chk_wake_hold: assert property (!woke |-> ff == {NUM_CELLS{FF_WAKE_VALUE}})
        else $error("Flip-flops left the wake-up value without a load");

    // Shared clock tick
    chk_hold_no_tick: assert property (!tick && !sr_apply |=> ff == $past(ff))
        else $error("Flip-flop changed without a shared clock tick");
    chk_tick_once: assert property ($past(nrst) && $past(sel_clk)
        && $stable(block_cfg.clk_sel) |-> !tick)
        else $error("Tick while the selected clock stayed high");
    chk_fabric_tick: assert property (block_cfg.clk_sel == CLK_SEL_FABRIC
        && $past(block_cfg.clk_sel) == CLK_SEL_FABRIC && fabric_clock
        && !$past(fabric_clock) |-> tick)
        else $error("Fabric clock edge gave no tick");
    chk_global_clock_buffer_tick: assert property (block_cfg.clk_sel != CLK_SEL_FABRIC
        && $stable(block_cfg.clk_sel) && global_clock_buffer[block_cfg.clk_sel[2:0]]
        && !$past(global_clock_buffer[block_cfg.clk_sel[2:0]]) |-> tick)
        else $error("Buffer clock edge gave no tick");

    // Shared clock enable
    chk_enable_gates: assert property (tick && !ce_on && !sr_apply |=> ff == $past(ff))
        else $error("Disabled block flip-flops changed");
    chk_ff_load: assert property (tick && ce_on && !sr_apply |=> ff == $past(lut_val))
        else $error("Flip-flops did not load table results");
    chk_ce_unused: assert property (!block_cfg.ce_used && tick && !sr_apply |=> ff == $past(lut_val))
        else $error("Unused enable blocked a load");
    chk_odd_ce_src: assert property (block_cfg.ce_used && block_cfg.ce_from_global_clock_buffer
        && !global_clock_buffer[{block_cfg.ce_global_clock_buffer_pair, 1'b1}] && !sr_apply
        |=> ff == $past(ff))
        else $error("Enable not taken from an odd buffer");

    // Shared set/reset
    chk_sr_async: assert property (block_cfg.sr_used && block_cfg.sr_async && sr_sig
        |=> ff == $past(sr_vals))
        else $error("Asynchronous set/reset not applied at once");
    chk_async_no_tick: assert property (sr_async_hit && !tick |=> ff == $past(sr_vals))
        else $error("Asynchronous set/reset waited for a tick");
    chk_sr_sync_wait: assert property (block_cfg.sr_used && !block_cfg.sr_async && sr_sig
        && !tick |=> ff == $past(ff))
        else $error("Synchronous set/reset acted without a tick");
    chk_sr_sync_tick: assert property (block_cfg.sr_used && !block_cfg.sr_async && sr_sig
        && tick |=> ff == $past(sr_vals))
        else $error("Synchronous set/reset not applied on a tick");
    chk_sync_ignores_ce: assert property (sr_sync_hit && !ce_on |=> ff == $past(sr_vals))
        else $error("Synchronous set/reset gated by the enable");
    chk_sr_priority: assert property (sr_apply && load_en |=> ff == $past(sr_vals))
        else $error("Load overrode set/reset");
    chk_sr_unused: assert property (!block_cfg.sr_used && load_en |=> ff == $past(lut_val))
        else $error("Unused set/reset changed a flip-flop");
    chk_even_sr_src: assert property (block_cfg.sr_used && block_cfg.sr_async
        && block_cfg.sr_from_global_clock_buffer && global_clock_buffer[{block_cfg.sr_global_clock_buffer_pair, 1'b0}]
        |=> ff == $past(sr_vals))
        else $error("Set/reset not taken from an even buffer");
    chk_sr_not_odd: assert property (block_cfg.sr_used && block_cfg.sr_from_global_clock_buffer
        && !global_clock_buffer[{block_cfg.sr_global_clock_buffer_pair, 1'b0}] && !load_en
        |=> ff == $past(ff))
        else $error("Set/reset followed a buffer other than its even one");

    // Outputs and carry chain
    chk_out_select: assert property (1'b1 |=> cell_out == $past(out_mux))
        else $error("Cell output does not follow selected source");
    chk_carry_ripple: assert property (1'b1 |=>
        carry_chain_out == $past(add_sum[NUM_CELLS]))
        else $error("Carry chain out differs from reference sum");
    chk_lut_lsb: assert property (lut_in[0] == 4'h1 && !cell_cfg[0].reg_out
        |=> cell_out[0] == $past(cell_cfg[0].lut_init[1]))
        else $error("Table address bit order wrong");

    // Per-cell output select, set/reset value and carry
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CELLS; gc++) begin : g_cell_chk
            chk_cell_table: assert property (@(posedge clk_sys) disable iff (!nrst)
                !cell_cfg[gc].reg_out
                |=> cell_out[gc] == $past(cell_cfg[gc].lut_init[lut_in[gc]]))
                else $error("Cell table output wrong");
            chk_cell_reg: assert property (@(posedge clk_sys) disable iff (!nrst)
                cell_cfg[gc].reg_out |=> cell_out[gc] == $past(ff[gc]))
                else $error("Cell registered output wrong");
            chk_cell_set: assert property (@(posedge clk_sys) disable iff (!nrst)
                sr_apply |=> ff[gc] == $past(cell_cfg[gc].sr_to_set))
                else $error("Cell set/reset value wrong");
            chk_cell_keep: assert property (@(posedge clk_sys) disable iff (!nrst)
                lut_in[gc][1] != lut_in[gc][2] |-> carry[gc+1] == carry[gc])
                else $error("Cell carry did not propagate");
            chk_cell_make: assert property (@(posedge clk_sys) disable iff (!nrst)
                lut_in[gc][1] == lut_in[gc][2] |-> carry[gc+1] == lut_in[gc][1])
                else $error("Cell carry not generated or killed");
        end
    endgenerate

    cov_load_tick: cover property (tick && ce_on && !sr_apply);
    cov_async_sr: cover property (block_cfg.sr_async && sr_apply && !tick);
    cov_sync_sr: cover property (sr_sync_hit && !ce_on);
    cov_carry_out: cover property (carry[NUM_CELLS]);
    cov_fabric_clk: cover property (block_cfg.clk_sel == CLK_SEL_FABRIC && tick);
endmodule

// file: hw/programmable_logic_block_pkg.sv
// Shared constants and configuration structs for the programmable logic block
package programmable_logic_block_pkg;
    localparam int NUM_CELLS = 8;
    localparam int LUT_INPUTS = 4;
    localparam int LUT_DEPTH = 16;
    localparam int NUM_GLOBAL_BUFFERS = 8;
    localparam logic [3:0] CLK_SEL_FABRIC = 4'h8;
    localparam logic FF_WAKE_VALUE = 1'b0;
    localparam logic [15:0] LUT_INIT_RESET = 16'h0000;

    typedef struct packed {
        logic [LUT_DEPTH-1:0] lut_init;
        logic reg_out;
        logic sr_to_set;
    } cell_cfg_s;

    typedef struct packed {
        logic [3:0] clk_sel;
        logic ce_used;
        logic ce_from_global_clock_buffer;
        logic [1:0] ce_global_clock_buffer_pair;
        logic sr_used;
        logic sr_async;
        logic sr_from_global_clock_buffer;
        logic [1:0] sr_global_clock_buffer_pair;
    } block_cfg_s;
endpackage

// file: tb/neighbour_carry_model.sv
// Upstream neighbour block that drives a registered carry into the chain
`timescale 1ns/100ps
module neighbour_carry_model (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [1:0] operand,
    output logic carry_out
);
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            carry_out <= 1'b0;
        end else begin
            carry_out <= &operand;
        end
    end
endmodule

// file: tb/programmable_logic_block_bench.sv
// Random self-checking bench with a cycle model of the logic block
`timescale 1ns/100ps
module programmable_logic_block_bench;
    import programmable_logic_block_pkg::*;
    logic clk_sys = 1'b0, nrst = 1'b0, fclk = 1'b0, fen = 1'b0, fsr = 1'b0;
    logic [7:0] gcb = '0, cell_out, ff = '0;
    logic [1:0] op = '0;
    logic cin, cout, prev = 1'b0;
    block_cfg_s bcfg = '0;
    cell_cfg_s [7:0] ccfg = '0;
    logic [7:0][3:0] lut_in = '0;
    logic [9:0] q[$];
    int seed = 32'h3245, num_errors = 0, checks = 0, cyc = 0;
    neighbour_carry_model i_neighbour_carry_model (.clk_sys(clk_sys), .nrst(nrst),
        .operand(op), .carry_out(cin));
    programmable_logic_block i_programmable_logic_block (.clk_sys(clk_sys), .nrst(nrst),
        .global_clock_buffer(gcb), .fabric_clock(fclk), .fabric_enable(fen),
        .fabric_set_reset(fsr), .block_cfg(bcfg), .cell_cfg(ccfg), .lut_in(lut_in),
        .carry_chain_in(cin), .cell_out(cell_out), .carry_chain_out(cout));
    always #25 clk_sys = ~clk_sys;
    task automatic final_report;
        if (num_errors == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys) begin : drive
        logic [7:0] lut, e;
        logic [31:0] r;
        logic src, tk, ce, sr, c;
        c = cin;
        src = (bcfg.clk_sel == CLK_SEL_FABRIC) ? fclk : gcb[bcfg.clk_sel[2:0]];
        ce = !bcfg.ce_used | (bcfg.ce_from_global_clock_buffer ? gcb[{bcfg.ce_global_clock_buffer_pair, 1'b1}] : fen);
        sr = bcfg.sr_used & (bcfg.sr_from_global_clock_buffer ? gcb[{bcfg.sr_global_clock_buffer_pair, 1'b0}] : fsr);
        tk = src & !prev;
        for (int i = 0; i < 8; i++) begin
            lut[i] = ccfg[i].lut_init[lut_in[i]];
            c = (lut_in[i][1] & lut_in[i][2]) | ((lut_in[i][1] | lut_in[i][2]) & c);
            e[i] = ccfg[i].reg_out ? ff[i] : lut[i];
            if (sr && (bcfg.sr_async || tk)) ff[i] = ccfg[i].sr_to_set;
            else if (tk && ce) ff[i] = lut[i];
        end
        if (!nrst) begin
            q.push_back(10'h000);
            ff = '0;
            prev = 1'b0;
        end else begin
            q.push_back({c, e});
            prev = src;
        end
        r = $random(seed);
        nrst <= cyc >= 20 && r[31:26] != 6'h00;
        gcb <= r[15:8];
        fclk <= r[0];
        fen <= r[1];
        fsr <= r[2];
        op <= r[4:3];
        lut_in <= $random(seed);
        if (cyc % 64 == 0) begin
            bcfg <= block_cfg_s'(13'($random(seed)));
            for (int i = 0; i < 8; i++) ccfg[i] <= cell_cfg_s'(18'($random(seed)));
        end
        cyc++;
        if (cyc > 4000) begin
            num_errors++;
            final_report();
        end
    end
    always @(negedge clk_sys) if (q.size() > 0) begin : watch
        logic [9:0] x;
        x = q.pop_front();
        checks++;
        if ({cout, cell_out} !== x) begin
            $display("wrong value at %0t: got %h expected %h", $time, {cout, cell_out}, x);
            num_errors++;
        end
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        final_report();
    end
endmodule
